// [inc/ccc_pkg.sv]
// Package for the charge cycle control block: timing figures, defaults,
// encodings and the structs that carry configuration, analog inputs and flags.
// Assumes a single 250 MHz system clock.
package ccc_pkg;

	localparam int CLK_MHZ = 250;
	localparam int PAUSE_TIME_US = 1000;
	localparam int INT_PULSE_US = 128;
	localparam int WD_TIME_S = 50;
	localparam int SEC_PER_MIN = 60;
	localparam int US_PER_S = 1000000;

	localparam longint unsigned PAUSE_CYC = longint'(PAUSE_TIME_US) * CLK_MHZ;
	localparam longint unsigned INT_PULSE_CYC = longint'(INT_PULSE_US) * CLK_MHZ;
	localparam longint unsigned WD_CYC = longint'(WD_TIME_S) * US_PER_S * CLK_MHZ;
	localparam longint unsigned MIN_CYC = longint'(SEC_PER_MIN) * US_PER_S * CLK_MHZ;

	localparam int CNT_W = 34;
	localparam int MIN_W = 10;
	localparam int CUR_W = 8;

	// Safety time choices in minutes, selected by a two-bit code
	localparam logic [MIN_W-1:0] TMR_MIN_0 = 10'h0b4;
	localparam logic [MIN_W-1:0] TMR_MIN_1 = 10'h168;
	localparam logic [MIN_W-1:0] TMR_MIN_2 = 10'h21c;
	localparam logic [MIN_W-1:0] TMR_MIN_3 = 10'h2d0;

	localparam logic [2:0] SYSTEM_RAIL_TRACK = 3'h0;
	localparam logic [1:0] ZONE_NORMAL = 2'h0;
	localparam logic [1:0] ZONE_COOL = 2'h1;
	localparam logic [1:0] ZONE_WARM = 2'h2;

	typedef struct packed {
		logic chargeDisable;
		logic wdEnable;
		logic timerDoubling;
		logic [1:0] tmrSel;
		logic vinLoopEnable;
		logic [2:0] vinLoopSel;
		logic [2:0] pmidRegSel;
		logic [CUR_W-1:0] fastCur;
		logic [CUR_W-1:0] preCur;
		logic [CUR_W-1:0] termCur;
	} ccc_cfg_t;

	localparam ccc_cfg_t CFG_RESET = '{
		chargeDisable: 1'h0, wdEnable: 1'h1, timerDoubling: 1'h0, tmrSel: 2'h0,
		vinLoopEnable: 1'h0, vinLoopSel: 3'h0, pmidRegSel: 3'h1,
		fastCur: 8'h0a, preCur: 8'h02, termCur: 8'h01};

	typedef struct packed {
		logic vinValid;
		logic vinOvp;
		logic belowPrecharge;
		logic cvActive;
		logic vinLoopRaw;
		logic droopLoopRaw;
		logic thermRegActive;
		logic [1:0] tsZone;
		logic sysBelowEntry;
		logic sysAboveExit;
		logic atTermCurrent;
	} ccc_analog_t;

	typedef struct packed {
		logic preCharge;
		logic fastCharge;
		logic chargeDone;
		logic timerFault;
		logic vinLoopActive;
		logic droopLoopActive;
		logic supplement;
		logic overvoltage;
	} ccc_status_t;

	typedef struct packed {
		logic overvoltageFlag;
		logic vinLoopFlag;
		logic droopLoopFlag;
		logic timerExpiredFlag;
	} ccc_flags_t;

	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_PRE = 5'h02,
		ST_FAST = 5'h04,
		ST_DONE = 5'h08,
		ST_FAULT = 5'h10
	} ccc_state_t;

endpackage

// [rtl/ccc_sync.sv]
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level; multi-bit codes may tear for one cycle.
`timescale 1ns/1ns
`default_nettype none
module ccc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// [rtl/ccc_charge_ctrl.sv]
// Charge cycle control: enable, phases, termination, current-change pause,
// power-loop flags, over-voltage handling, safety timer and host watchdog.
// Assumes analog comparators, pins and the serial bus lines arrive asynchronous.
// Notes on behaviour
// - Charge only when enable pin low and inhibit bit clear.
// - Below precharge threshold use precharge current; timer limit is a quarter.
// - At precharge threshold move to fast charge at fast current.
// - Stop charging when current reaches termination level, if qualified.
// - Termination qualifies only with constant-voltage loop active in fast charge.
// - No termination while input, droop or thermal loop is active.
// - No termination in the warm temperature zone.
// - Any charge current change pauses charging about one millisecond first.
// - Input-voltage loop off after reset, host enables; 4.2 to 4.9 V code.
// - Droop loop disabled when system rail setting selects battery tracking.
// - Active input or droop loop sets status bits and event flags.
// - Supplement entered below entry offset, left above exit offset.
// - Termination inhibited while in supplement.
// - Over-voltage opens input switch, one 128 us interrupt pulse, sets flags.
// - Over-voltage status follows fault; flag clears on read after fault gone.
// - Timer starts with charge cycle; expiry without termination disables charging.
// - Expiry gives one 128 us pulse and sets timer-expired flag.
// - Timer-expired flag clears on read even if fault persists.
// - Changing timer duration while running restarts the timer.
// - With doubling, timer runs half rate while non-CC/CV loops act.
// - 50 s watchdog, on after reset, kicked by bus traffic, restores defaults.
`timescale 1ns/1ns
`default_nettype none
module ccc_charge_ctrl
	import ccc_pkg::*;
#(
	parameter longint unsigned PAUSE_CYCLES = ccc_pkg::PAUSE_CYC,
	parameter longint unsigned INT_CYCLES = ccc_pkg::INT_PULSE_CYC,
	parameter longint unsigned WD_CYCLES = ccc_pkg::WD_CYC,
	parameter longint unsigned MIN_CYCLES = ccc_pkg::MIN_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic chargeEnablePin_n,
	input wire ccc_pkg::ccc_analog_t analogIn,
	input wire logic busClk,
	input wire logic busData,
	input wire logic cfgWrite,
	input wire ccc_pkg::ccc_cfg_t cfgWrData,
	input wire logic flagsRead,
	input wire logic thirdFlagsRead,
	output ccc_pkg::ccc_cfg_t cfgOut,
	output ccc_pkg::ccc_status_t status,
	output ccc_pkg::ccc_flags_t flags,
	output logic [ccc_pkg::CUR_W-1:0] chargeCurrent,
	output logic chargeSwitchOn,
	output logic inputSwitchOn,
	output logic interrupt_n
);
	import ccc_pkg::*;

	localparam int SYNC_W = $bits(ccc_analog_t) + 3;

	if (PAUSE_CYCLES < 2 || INT_CYCLES < 2 || WD_CYCLES < 2 || MIN_CYCLES < 2) begin : gChkMin
		$error("cycle counts must be at least two");
	end
	if (PAUSE_CYCLES >= (64'h1 << CNT_W) || INT_CYCLES >= (64'h1 << CNT_W) ||
		WD_CYCLES >= (64'h1 << CNT_W) || MIN_CYCLES >= (64'h1 << CNT_W)) begin : gChkMax
		$error("cycle count exceeds counter width");
	end

	function automatic logic [MIN_W-1:0] tmrMinutes(input logic [1:0] sel);
		case (sel)
			2'h0: tmrMinutes = TMR_MIN_0;
			2'h1: tmrMinutes = TMR_MIN_1;
			2'h2: tmrMinutes = TMR_MIN_2;
			default: tmrMinutes = TMR_MIN_3;
		endcase
	endfunction

	logic [SYNC_W-1:0] syncOut;
	ccc_analog_t ana;
	logic ceActive;
	logic sclS;
	logic sdaS;

	ccc_sync #(.WIDTH(SYNC_W)) uSync (
		.clk_sys(clk_sys),
		.srst(srst),
		// Pin inverted ahead of the flops so their reset value reads as disabled
		.d({analogIn, !chargeEnablePin_n, busClk, busData}),
		.q(syncOut)
	);
	assign {ana, ceActive, sclS, sdaS} = syncOut;

	ccc_cfg_t cfg_q;
	ccc_state_t state_q;
	logic supplement_q;
	logic sdaPrev_q;
	logic wdExpire_q;
	logic [CNT_W-1:0] wdCnt_q;
	logic [CNT_W-1:0] tickCnt_q;
	logic [MIN_W-1:0] minCnt_q;
	logic [1:0] tmrSelPrev_q;
	logic halfPhase_q;
	logic [CNT_W-1:0] pauseCnt_q;
	logic [CUR_W-1:0] applied_q;
	logic [CNT_W-1:0] intCnt_q;
	logic ovpPrev_q;
	logic vinLoopPrev_q;
	logic droopPrev_q;
	ccc_flags_t flags_q;

	logic enable;
	logic running;
	logic vinLoopAct;
	logic droopLoopAct;
	logic termQualified;
	logic slowLoop;
	logic tmrStep;
	logic tmrRestart;
	logic tmrExpire;
	logic [MIN_W-1:0] tmrLimit;
	logic [CUR_W-1:0] targetCur;
	logic busStart;
	logic ovpRise;
	logic pulseReq;

	assign enable = ceActive && !cfg_q.chargeDisable && ana.vinValid && !ana.vinOvp;
	assign running = (state_q == ST_PRE) || (state_q == ST_FAST);
	assign vinLoopAct = ana.vinLoopRaw && cfg_q.vinLoopEnable;
	assign droopLoopAct = ana.droopLoopRaw && (cfg_q.pmidRegSel != SYSTEM_RAIL_TRACK);
	// Termination only when the taper comes from reaching target voltage
	assign termQualified = (state_q == ST_FAST) && ana.cvActive
		&& !vinLoopAct && !droopLoopAct && !ana.thermRegActive
		&& (ana.tsZone != ZONE_WARM)
		&& !supplement_q;

	// Configuration registers, restored wholesale by the watchdog
	always_ff @(posedge clk_sys) begin
		if (srst || wdExpire_q) begin
			cfg_q <= CFG_RESET;
		end else if (cfgWrite) begin
			cfg_q <= cfgWrData;
		end
	end

	// Bus start condition: data falls while clock high
	assign busStart = sclS && sdaPrev_q && !sdaS;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sdaPrev_q <= 1'b1;
			wdCnt_q <= '0;
			wdExpire_q <= 1'b0;
		end else begin
			sdaPrev_q <= sdaS;
			wdExpire_q <= 1'b0;
			if (!cfg_q.wdEnable || busStart || cfgWrite || flagsRead || thirdFlagsRead) begin
				wdCnt_q <= '0;
			end else if (wdCnt_q == CNT_W'(WD_CYCLES - 1)) begin
				wdCnt_q <= '0;
				wdExpire_q <= 1'b1;
			end else begin
				wdCnt_q <= wdCnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			supplement_q <= 1'b0;
		end else if (ana.sysBelowEntry) begin
			supplement_q <= 1'b1;
		end else if (ana.sysAboveExit) begin
			supplement_q <= 1'b0;
		end
	end

	// Safety timer: minute prescaler plus minute counter
	assign tmrLimit = (state_q == ST_PRE) ? (tmrMinutes(cfg_q.tmrSel) >> 2) : tmrMinutes(cfg_q.tmrSel);
	assign slowLoop = cfg_q.timerDoubling && (vinLoopAct || droopLoopAct || ana.thermRegActive);
	assign tmrStep = !slowLoop || halfPhase_q;
	assign tmrRestart = !running || (cfg_q.tmrSel != tmrSelPrev_q);
	assign tmrExpire = running && (minCnt_q >= tmrLimit);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tmrSelPrev_q <= CFG_RESET.tmrSel;
			halfPhase_q <= 1'b0;
		end else begin
			tmrSelPrev_q <= cfg_q.tmrSel;
			halfPhase_q <= !halfPhase_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst || tmrRestart) begin
			tickCnt_q <= '0;
			minCnt_q <= '0;
		end else if (tmrStep) begin
			if (tickCnt_q == CNT_W'(MIN_CYCLES - 1)) begin
				tickCnt_q <= '0;
				minCnt_q <= minCnt_q + 1'b1;
			end else begin
				tickCnt_q <= tickCnt_q + 1'b1;
			end
		end
	end

	// Charge phases; a disable is the only way out of done or fault
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= ST_OFF;
		end else if (!enable) begin
			state_q <= ST_OFF;
		end else begin
			case (state_q)
				ST_OFF: state_q <= ana.belowPrecharge ? ST_PRE : ST_FAST;
				ST_PRE: begin
					if (tmrExpire) begin
						state_q <= ST_FAULT;
					end else if (!ana.belowPrecharge) begin
						state_q <= ST_FAST;
					end
				end
				ST_FAST: begin
					if (termQualified && ana.atTermCurrent) begin
						state_q <= ST_DONE;
					end else if (tmrExpire) begin
						state_q <= ST_FAULT;
					end
				end
				ST_DONE: state_q <= ST_DONE;
				ST_FAULT: state_q <= ST_FAULT;
				default: state_q <= ST_OFF;
			endcase
		end
	end

	// Target current; cool and warm zones run at half the fast current
	always_comb begin
		// Idle follows the coming phase, so a fresh start needs no pause
		if (state_q == ST_PRE || (!running && ana.belowPrecharge)) begin
			targetCur = cfg_q.preCur;
		end else if (ana.tsZone == ZONE_COOL || ana.tsZone == ZONE_WARM) begin
			targetCur = cfg_q.fastCur >> 1;
		end else begin
			targetCur = cfg_q.fastCur;
		end
	end

	// Pause before a new current value takes effect
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pauseCnt_q <= '0;
			applied_q <= CFG_RESET.preCur;
		end else if (!running) begin
			pauseCnt_q <= '0;
			applied_q <= targetCur;
		end else if (pauseCnt_q != '0) begin
			pauseCnt_q <= pauseCnt_q - 1'b1;
			if (pauseCnt_q == CNT_W'(1)) begin
				applied_q <= targetCur;
			end
		end else if (targetCur != applied_q) begin
			pauseCnt_q <= CNT_W'(PAUSE_CYCLES);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			chargeSwitchOn <= 1'b0;
			inputSwitchOn <= 1'b0;
		end else begin
			chargeSwitchOn <= running && (pauseCnt_q == '0) && (targetCur == applied_q);
			inputSwitchOn <= ana.vinValid && !ana.vinOvp;
		end
	end

	// Event flags; a set in the same cycle as a read wins
	assign ovpRise = ana.vinOvp && !ovpPrev_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ovpPrev_q <= 1'b0;
			vinLoopPrev_q <= 1'b0;
			droopPrev_q <= 1'b0;
			flags_q <= '0;
		end else begin
			ovpPrev_q <= ana.vinOvp;
			vinLoopPrev_q <= vinLoopAct;
			droopPrev_q <= droopLoopAct;
			if (ovpRise) begin
				flags_q.overvoltageFlag <= 1'b1;
			end else if (flagsRead && !ana.vinOvp) begin
				flags_q.overvoltageFlag <= 1'b0;
			end
			if (vinLoopAct && !vinLoopPrev_q) begin
				flags_q.vinLoopFlag <= 1'b1;
			end else if (flagsRead) begin
				flags_q.vinLoopFlag <= 1'b0;
			end
			if (droopLoopAct && !droopPrev_q) begin
				flags_q.droopLoopFlag <= 1'b1;
			end else if (flagsRead) begin
				flags_q.droopLoopFlag <= 1'b0;
			end
			if (tmrExpire) begin
				flags_q.timerExpiredFlag <= 1'b1;
			end else if (thirdFlagsRead) begin
				flags_q.timerExpiredFlag <= 1'b0;
			end
		end
	end

	// Pulse only when a flag goes from clear to set
	assign pulseReq = (ovpRise && !flags_q.overvoltageFlag) || (tmrExpire && !flags_q.timerExpiredFlag);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			intCnt_q <= '0;
			interrupt_n <= 1'b1;
		end else if (pulseReq) begin
			intCnt_q <= CNT_W'(INT_CYCLES);
			interrupt_n <= 1'b0;
		end else if (intCnt_q != '0) begin
			intCnt_q <= intCnt_q - 1'b1;
			if (intCnt_q == CNT_W'(1)) begin
				interrupt_n <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			status <= '0;
			chargeCurrent <= CFG_RESET.preCur;
		end else begin
			status.preCharge <= (state_q == ST_PRE);
			status.fastCharge <= (state_q == ST_FAST);
			status.chargeDone <= (state_q == ST_DONE);
			status.timerFault <= (state_q == ST_FAULT);
			status.vinLoopActive <= vinLoopAct;
			status.droopLoopActive <= droopLoopAct;
			status.supplement <= supplement_q;
			status.overvoltage <= ana.vinOvp;
			chargeCurrent <= applied_q;
		end
	end

	assign cfgOut = cfg_q;
	assign flags = flags_q;

endmodule
`default_nettype wire

// [verif/ccc_charge_ctrl_asserts.sv]
// Port checker for the charge control block.
// Assumes the short timing parameters handed on by the bind.
`timescale 1ns/1ns
`default_nettype none
module ccc_charge_ctrl_asserts
	import ccc_pkg::*;
#(
	parameter longint unsigned PAUSE_CYCLES = 20,
	parameter longint unsigned INT_CYCLES = 16
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic chargeEnablePin_n,
	input wire logic cfgWrite,
	input wire ccc_pkg::ccc_cfg_t cfgWrData,
	input wire logic thirdFlagsRead,
	input wire ccc_pkg::ccc_cfg_t cfgOut,
	input wire ccc_pkg::ccc_status_t status,
	input wire ccc_pkg::ccc_flags_t flags,
	input wire logic [ccc_pkg::CUR_W-1:0] chargeCurrent,
	input wire logic chargeSwitchOn,
	input wire logic inputSwitchOn,
	input wire logic interrupt_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	int lowCnt_q;
	int offCnt_q;
	always_ff @(posedge clk_sys) begin
		lowCnt_q <= (srst || interrupt_n) ? 0 : lowCnt_q + 1;
	end
	always_ff @(posedge clk_sys) begin
		offCnt_q <= (srst || chargeSwitchOn) ? 0 : offCnt_q + 1;
	end
	// Pin passes two sync flops, the state and the switch register
	sequence pinHigh;
		chargeEnablePin_n [*5];
	endsequence
	chk_pin_gate: assert property (pinHigh |=> !chargeSwitchOn) else $error("switch on with pin high");
	chk_inhibit_bit: assert property (cfgOut.chargeDisable [*3] |=> !chargeSwitchOn) else $error("switch on while inhibited");
	chk_pulse_width: assert property ($rose(interrupt_n) |-> lowCnt_q == int'(INT_CYCLES)) else $error("pulse width wrong");
	chk_pulse_cause: assert property ($fell(interrupt_n) |-> ##[0:2] (flags.overvoltageFlag || flags.timerExpiredFlag))
		else $error("pulse without flag");
	chk_ovp_input: assert property (status.overvoltage [*2] |-> !inputSwitchOn) else $error("input switch closed in fault");
	chk_ovp_flag: assert property ($rose(status.overvoltage) |-> ##[0:1] flags.overvoltageFlag) else $error("fault flag not set");
	chk_ovp_sticky: assert property (status.overvoltage [*2] |-> flags.overvoltageFlag) else $error("fault flag lost");
	chk_timer_read: assert property (thirdFlagsRead && status.timerFault |=> !flags.timerExpiredFlag)
		else $error("timer flag kept");
	chk_cfg_write: assert property (cfgWrite |=> cfgOut == $past(cfgWrData)) else $error("config not written");
	chk_pause_len: assert property ($changed(chargeCurrent) && status.fastCharge && $past(status.fastCharge)
		|-> offCnt_q >= int'(PAUSE_CYCLES) - 2) else $error("no pause before new current");
	chk_term_block: assert property ($rose(status.chargeDone) |-> $past(status.fastCharge && !status.supplement
		&& !status.vinLoopActive && !status.droopLoopActive)) else $error("termination not qualified");
endmodule
bind ccc_charge_ctrl ccc_charge_ctrl_asserts #(.PAUSE_CYCLES(PAUSE_CYCLES), .INT_CYCLES(INT_CYCLES)) u_ccc_charge_ctrl_asserts (
	.clk_sys(clk_sys), .srst(srst), .chargeEnablePin_n(chargeEnablePin_n), .cfgWrite(cfgWrite),
	.cfgWrData(cfgWrData), .thirdFlagsRead(thirdFlagsRead), .cfgOut(cfgOut), .status(status), .flags(flags),
	.chargeCurrent(chargeCurrent), .chargeSwitchOn(chargeSwitchOn), .inputSwitchOn(inputSwitchOn),
	.interrupt_n(interrupt_n));
`default_nettype wire

// [verif/ccc_host_model.sv]
// Host model: serial bus frames and an interrupt pulse counter.
// Assumes pulled-up bus lines that stand high between frames.
`timescale 1ns/1ns
`default_nettype none
module ccc_host_model (
	input wire logic interrupt_n,
	output var logic busClk,
	output var logic busData,
	output var int intCount
);
	initial begin
		busClk = 1'b1;
		busData = 1'b1;
		intCount = 0;
	end
	always @(negedge interrupt_n) begin
		intCount++;
	end
	// Start, four 64 ns bits, stop; clock stands still outside
	task automatic frame();
		#16 busData = 1'b0;
		#16 busClk = 1'b0;
		repeat (4) begin
			#32 busClk = 1'b1;
			#32 busClk = 1'b0;
		end
		#16 busClk = 1'b1;
		#16 busData = 1'b1;
	endtask
endmodule
`default_nettype wire

// [verif/ccc_charge_ctrl_tb.sv]
// Self-checking bench for the charge control block with a host model.
// Assumes shortened pause, pulse, watchdog and minute counts.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin numErrors++; \
	$display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module ccc_charge_ctrl_tb;
	import ccc_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic pinN = 1'b1;
	ccc_analog_t ana = '0;
	logic busClk;
	logic busData;
	logic cfgWrite = 1'b0;
	ccc_cfg_t wrData = CFG_RESET;
	logic flagsRead = 1'b0;
	logic thirdRead = 1'b0;
	ccc_cfg_t cfgOut;
	ccc_status_t status;
	ccc_flags_t flags;
	logic [CUR_W-1:0] cur;
	logic swOn;
	logic inOn;
	logic intN;
	int intCount;
	int numErrors = 0;
	int samplesChecked = 0;
	int n0;
	always #2 clk_sys = ~clk_sys;
	ccc_charge_ctrl #(.PAUSE_CYCLES(20), .INT_CYCLES(16), .WD_CYCLES(200), .MIN_CYCLES(10)) u_ccc_charge_ctrl (
		.clk_sys(clk_sys), .srst(srst), .chargeEnablePin_n(pinN), .analogIn(ana), .busClk(busClk),
		.busData(busData), .cfgWrite(cfgWrite), .cfgWrData(wrData), .flagsRead(flagsRead),
		.thirdFlagsRead(thirdRead), .cfgOut(cfgOut), .status(status), .flags(flags), .chargeCurrent(cur),
		.chargeSwitchOn(swOn), .inputSwitchOn(inOn), .interrupt_n(intN));
	ccc_host_model u_ccc_host_model (.interrupt_n(intN), .busClk(busClk), .busData(busData), .intCount(intCount));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wr(input ccc_cfg_t c);
		@(negedge clk_sys);
		cfgWrite = 1'b1;
		wrData = c;
		@(negedge clk_sys);
		cfgWrite = 1'b0;
	endtask
	task automatic rd(input logic third);
		@(negedge clk_sys);
		flagsRead = !third;
		thirdRead = third;
		@(negedge clk_sys);
		flagsRead = 1'b0;
		thirdRead = 1'b0;
	endtask
	task automatic giveVerdict();
		$display("checks %0d errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#40000;
		numErrors++;
		giveVerdict();
	end
	initial begin
		ccc_cfg_t c;
		cyc(12);
		srst = 1'b0;
		cyc(2);
		`CHK("cfgReset", CFG_RESET, cfgOut)
		`CHK("intIdle", 1'b1, intN)
		// Watchdog off here, else it would undo the test settings
		c = CFG_RESET;
		c.wdEnable = 1'b0;
		c.vinLoopEnable = 1'b1;
		wr(c);
		ana.vinValid = 1'b1;
		ana.belowPrecharge = 1'b1;
		pinN = 1'b0;
		cyc(10);
		`CHK("preCharge", 1'b1, status.preCharge)
		`CHK("preCur", c.preCur, cur)
		`CHK("switchOn", 1'b1, swOn)
		cyc(290);
		// Two duration changes restart the timer, moving expiry past 450 cycles
		c.tmrSel = 2'h1;
		wr(c);
		c.tmrSel = 2'h0;
		wr(c);
		cyc(370);
		`CHK("noFaultYet", 1'b0, status.timerFault)
		n0 = intCount;
		cyc(100);
		`CHK("timerFault", 1'b1, status.timerFault)
		`CHK("timerFlag", 1'b1, flags.timerExpiredFlag)
		`CHK("timerPulse", n0 + 1, intCount)
		`CHK("faultSwitch", 1'b0, swOn)
		rd(1'b1);
		cyc(40);
		`CHK("flagReadClr", 1'b0, flags.timerExpiredFlag)
		`CHK("faultStays", 1'b1, status.timerFault)
		`CHK("noRepulse", n0 + 1, intCount)
		pinN = 1'b1;
		cyc(8);
		`CHK("pinOff", 1'b0, swOn)
		`CHK("faultLeft", 1'b0, status.timerFault)
		// Half-rate timer under the input loop: expiry near 900 cycles, not 450
		c.timerDoubling = 1'b1;
		wr(c);
		ana.vinLoopRaw = 1'b1;
		pinN = 1'b0;
		cyc(700);
		`CHK("doubledRun", 1'b0, status.timerFault)
		cyc(300);
		`CHK("doubledFault", 1'b1, status.timerFault)
		pinN = 1'b1;
		ana.vinLoopRaw = 1'b0;
		cyc(8);
		`CHK("faultLeft2", 1'b0, status.timerFault)
		ana.belowPrecharge = 1'b0;
		pinN = 1'b0;
		cyc(40);
		`CHK("fastCharge", 1'b1, status.fastCharge)
		`CHK("fastCur", c.fastCur, cur)
		c.fastCur = 8'h20;
		wr(c);
		cyc(3);
		`CHK("pauseOff", 1'b0, swOn)
		`CHK("pauseOld", 8'h0a, cur)
		cyc(25);
		`CHK("pauseNew", 8'h20, cur)
		`CHK("pauseOn", 1'b1, swOn)
		c.chargeDisable = 1'b1;
		wr(c);
		cyc(4);
		`CHK("inhibitOff", 1'b0, swOn)
		c.chargeDisable = 1'b0;
		wr(c);
		cyc(40);
		for (int i = 0; i < 6; i++) begin
			ana.vinLoopRaw = (i == 0);
			ana.droopLoopRaw = (i == 1);
			ana.thermRegActive = (i == 2);
			ana.tsZone = (i == 3) ? ZONE_WARM : ZONE_NORMAL;
			ana.sysBelowEntry = (i == 5);
			ana.cvActive = (i != 4);
			cyc(4);
			ana.atTermCurrent = 1'b1;
			cyc(10);
			`CHK("termBlocked", 1'b0, status.chargeDone)
			`CHK("vinActive", (i == 0), status.vinLoopActive)
			`CHK("droopActive", (i == 1), status.droopLoopActive)
			ana.atTermCurrent = 1'b0;
			cyc(40);
		end
		`CHK("vinFlag", 1'b1, flags.vinLoopFlag)
		`CHK("droopFlag", 1'b1, flags.droopLoopFlag)
		`CHK("suppStay", 1'b1, status.supplement)
		ana.sysBelowEntry = 1'b0;
		ana.sysAboveExit = 1'b1;
		cyc(6);
		`CHK("suppExit", 1'b0, status.supplement)
		ana.sysAboveExit = 1'b0;
		ana.cvActive = 1'b1;
		ana.atTermCurrent = 1'b1;
		cyc(10);
		`CHK("termDone", 1'b1, status.chargeDone)
		`CHK("termOff", 1'b0, swOn)
		c.pmidRegSel = SYSTEM_RAIL_TRACK;
		wr(c);
		ana.droopLoopRaw = 1'b1;
		cyc(6);
		`CHK("droopTrack", 1'b0, status.droopLoopActive)
		ana.droopLoopRaw = 1'b0;
		n0 = intCount;
		ana.vinOvp = 1'b1;
		cyc(6);
		`CHK("ovpInput", 1'b0, inOn)
		`CHK("ovpStat", 1'b1, status.overvoltage)
		rd(1'b0);
		cyc(20);
		`CHK("ovpFlagHeld", 1'b1, flags.overvoltageFlag)
		`CHK("ovpPulse", n0 + 1, intCount)
		ana.vinOvp = 1'b0;
		cyc(6);
		`CHK("ovpStatClr", 1'b0, status.overvoltage)
		`CHK("ovpFlagStay", 1'b1, flags.overvoltageFlag)
		rd(1'b0);
		cyc(2);
		`CHK("ovpFlagClr", 1'b0, flags.overvoltageFlag)
		`CHK("inputBack", 1'b1, inOn)
		c = CFG_RESET;
		c.fastCur = 8'h30;
		wr(c);
		cyc(150);
		u_ccc_host_model.frame();
		`CHK("wdKicked", c, cfgOut)
		cyc(150);
		`CHK("wdRestore", CFG_RESET, cfgOut)
		giveVerdict();
	end
endmodule
`default_nettype wire
